// *** hdl/iowdt_pkg.sv ***
// Package with constants and carrier types for the I/O port watchdog timer.
package iowdt_pkg;
	localparam logic [15:0] IOWDT_PORT_ADDR = 16'h0443;
	localparam logic [5:0] IOWDT_CODE_MIN = 6'h01;
	localparam logic [5:0] IOWDT_CODE_MAX = 6'h3F;
	localparam int IOWDT_CODE_W = 6;
	localparam int IOWDT_CLK_HZ = 100000000;
	localparam int IOWDT_SEC_CYCLES = IOWDT_CLK_HZ;
	localparam logic [7:0] IOWDT_READ_IDLE = 8'h00;
	localparam int IOWDT_PULSE_MS = 1;
	localparam int IOWDT_PULSE_CYCLES = IOWDT_CLK_HZ / 1000 * IOWDT_PULSE_MS;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} iowdt_io_req_t;
endpackage

// *** hdl/iowdt_prescaler.sv ***
// Seconds prescaler that emits a one-cycle tick per period.
`timescale 1ns/1ps
module iowdt_prescaler
	import iowdt_pkg::*;
#(
	parameter int DIV = IOWDT_SEC_CYCLES
)
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Control.
	input wire logic restart_i,
	input wire logic run_i,
	output logic tick_o
);
	logic [31:0] cnt_r;

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt_r <= 32'h00000000;
			tick_o <= 1'b0;
		end
		else if (restart_i || !run_i)
		begin
			cnt_r <= 32'h00000000;
			tick_o <= 1'b0;
		end
		else if (cnt_r == 32'(DIV - 1))
		begin
			cnt_r <= 32'h00000000;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 32'h00000001;
			tick_o <= 1'b0;
		end
	end
endmodule // iowdt_prescaler

// *** hdl/iowdt_top.sv ***
// Watchdog timer reached through one host I/O port.
`timescale 1ns/1ps
module iowdt_top
	import iowdt_pkg::*;
#(
	parameter int SEC_CYCLES = IOWDT_SEC_CYCLES,
	parameter int PULSE_CYCLES = IOWDT_PULSE_CYCLES
)
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Host I/O bus, same clock domain.
	input wire iowdt_io_req_t io_req_i,
	output logic [7:0] io_rdata_o,
	// Expiry action.
	input wire logic action_irq_sel_i,
	output logic cpu_reset_o,
	output logic irq_o,
	// Status.
	output logic running_o
);
	logic hit_wr;
	logic hit_rd;
	logic tick;
	logic [IOWDT_CODE_W-1:0] remain_r;
	logic expire;
	logic [31:0] pulse_r;
	logic sel_meta_r;
	logic sel_sync_r;

	// The action select is a board strap from outside the clock domain.
	// Two stages keep a slow or bouncing strap from reaching the action logic
	// while it may still be metastable.
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sel_meta_r <= 1'b0;
			sel_sync_r <= 1'b0;
		end
		else
		begin
			sel_meta_r <= action_irq_sel_i;
			sel_sync_r <= sel_meta_r;
		end
	end

	assign hit_wr = io_req_i.wr && (io_req_i.addr == IOWDT_PORT_ADDR);
	assign hit_rd = io_req_i.rd && (io_req_i.addr == IOWDT_PORT_ADDR);
	// A code of zero is outside the range and does not arm the timer.
	assign expire = running_o && tick && (remain_r == 6'h01);

	iowdt_prescaler #(
		.DIV(SEC_CYCLES)
	) u_pre (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.restart_i(hit_wr),
		.run_i(running_o),
		.tick_o(tick)
	);

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			running_o <= 1'b0;
			remain_r <= 6'h00;
		end
		else if (hit_rd)
		begin
			running_o <= 1'b0;
			remain_r <= 6'h00;
		end
		else if (hit_wr)
		begin
			running_o <= (io_req_i.wdata[5:0] >= IOWDT_CODE_MIN);
			remain_r <= io_req_i.wdata[5:0];
		end
		else if (expire)
		begin
			running_o <= 1'b0;
			remain_r <= 6'h00;
		end
		else if (running_o && tick)
		begin
			remain_r <= remain_r - 6'h01;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cpu_reset_o <= 1'b0;
			irq_o <= 1'b0;
			pulse_r <= 32'h00000000;
		end
		else if (expire)
		begin
			cpu_reset_o <= !sel_sync_r;
			irq_o <= sel_sync_r;
			pulse_r <= 32'(PULSE_CYCLES - 1);
		end
		else if (pulse_r != 32'h00000000)
		begin
			pulse_r <= pulse_r - 32'h00000001;
		end
		else
		begin
			cpu_reset_o <= 1'b0;
			irq_o <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			io_rdata_o <= IOWDT_READ_IDLE;
		else
			io_rdata_o <= {2'b00, remain_r};
	end

	// Host accesses and timer states seen by the checks below.
	sequence s_host_write;
		hit_wr && !hit_rd;
	endsequence
	sequence s_zero_write;
		hit_wr && !hit_rd && (io_req_i.wdata[5:0] == 6'h00);
	endsequence
	sequence s_live_write;
		hit_wr && !hit_rd && (io_req_i.wdata[5:0] != 6'h00);
	endsequence
	sequence s_quiet;
		!running_o && (pulse_r == 32'h00000000);
	endsequence
	sequence s_plain_tick;
		running_o && tick && (remain_r > 6'h01) && !hit_wr && !hit_rd;
	endsequence

	property p_read_stops;
		@(posedge clock_i) disable iff (!arst_n_i)
		hit_rd |=> !running_o;
	endproperty
	a_read_stops: assert property (p_read_stops)
		else $error("Read did not stop the watchdog.");

	property p_write_arms;
		@(posedge clock_i) disable iff (!arst_n_i)
		s_live_write |=> running_o;
	endproperty
	a_write_arms: assert property (p_write_arms)
		else $error("Write did not arm the watchdog.");

	property p_load;
		@(posedge clock_i) disable iff (!arst_n_i)
		s_host_write |=> (remain_r == $past(io_req_i.wdata[5:0]));
	endproperty
	a_load: assert property (p_load)
		else $error("Interval was not reloaded.");

	property p_zero;
		@(posedge clock_i) disable iff (!arst_n_i)
		s_zero_write |=> !running_o;
	endproperty
	a_zero: assert property (p_zero)
		else $error("Zero code armed the watchdog.");

	property p_act;
		@(posedge clock_i) disable iff (!arst_n_i)
		expire |=> (irq_o == sel_sync_r) && (cpu_reset_o == !sel_sync_r);
	endproperty
	a_act: assert property (p_act)
		else $error("Wrong expiry action.");

	property p_idle;
		@(posedge clock_i) disable iff (!arst_n_i)
		s_quiet |=> !(cpu_reset_o || irq_o) || $past(expire);
	endproperty
	a_idle: assert property (p_idle)
		else $error("Action without expiry.");

	property p_expire_stops;
		@(posedge clock_i) disable iff (!arst_n_i)
		(expire && !hit_wr && !hit_rd) |=> !running_o;
	endproperty
	a_expire_stops: assert property (p_expire_stops)
		else $error("Watchdog kept running after expiry.");

	property p_countdown;
		@(posedge clock_i) disable iff (!arst_n_i)
		s_plain_tick |=> (remain_r == $past(remain_r) - 6'h01);
	endproperty
	a_countdown: assert property (p_countdown)
		else $error("Countdown did not step by one.");

	property p_one_action;
		@(posedge clock_i) disable iff (!arst_n_i)
		!(cpu_reset_o && irq_o);
	endproperty
	a_one_action: assert property (p_one_action)
		else $error("Reset and interrupt raised together.");
endmodule // iowdt_top

// *** bench/iowdt_host.sv ***
// Host model that drives the watchdog I/O port.
`timescale 1ns/1ps
module iowdt_host
	import iowdt_pkg::*;
(
	input wire logic clock_i,
	output iowdt_io_req_t io_req_o
);
	initial io_req_o = '0;
	task automatic access(input logic rd, input logic [7:0] d);
		@(posedge clock_i) #1;
		io_req_o = '{wr: !rd, rd: rd, addr: IOWDT_PORT_ADDR, wdata: d};
		@(posedge clock_i) #1;
		// A released bus must not keep showing the last address and data.
		io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~IOWDT_PORT_ADDR, wdata: ~d};
	endtask
endmodule // iowdt_host

// *** bench/io_port_watchdog_timer_test.sv ***
// Self-checking bench for the I/O port watchdog timer.
`timescale 1ns/1ps
module io_port_watchdog_timer_test;
	import iowdt_pkg::*;
	logic clock_i = 0;
	logic arst_n_i = 0;
	logic sel = 0;
	iowdt_io_req_t req;
	logic [7:0] rdata;
	logic rst_o, irq_o, run_o;
	int failures = 0;
	int cmp_count = 0;
	int n;
	// Each row holds the action select above the interval code.
	logic [6:0] rows [4] = '{7'h01, 7'h42, 7'h3F, 7'h7F};
	iowdt_host iowdt_host_i (.clock_i(clock_i), .io_req_o(req));
	iowdt_top #(.SEC_CYCLES(10), .PULSE_CYCLES(4)) iowdt_top_i (.clock_i(clock_i),
		.arst_n_i(arst_n_i), .io_req_i(req), .io_rdata_o(rdata), .action_irq_sel_i(sel),
		.cpu_reset_o(rst_o), .irq_o(irq_o), .running_o(run_o));
	initial forever #5 clock_i = ~clock_i;
	task automatic check(input string s, input logic [9:0] e, input logic [9:0] v);
		cmp_count++;
		if (e !== v)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic stop_test();
		$display("Mismatches %0d of %0d compares", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic expire(input logic [6:0] r);
		n = 0;
		while (!(rst_o | irq_o) && n < 700)
		begin
			@(posedge clock_i) #1;
			n++;
		end
		check("delay", 10'(n >= r[5:0] * 10 - 1 && n <= r[5:0] * 10 + 2), 1);
		check("action", {r[6], !r[6]}, {irq_o, rst_o});
		n = 0;
		while ((rst_o | irq_o) && n < 9)
		begin
			@(posedge clock_i) #1;
			n++;
		end
		check("pulse", 4, 10'(n));
		check("running", 0, run_o);
	endtask
	initial
	begin
		repeat (16) @(posedge clock_i);
		#1 arst_n_i = 1;
		check("idle", 0, {rst_o, irq_o, run_o});
		foreach (rows[i])
		begin
			sel = rows[i][6];
			iowdt_host_i.access(0, {2'h0, rows[i][5:0]});
			@(posedge clock_i) #1;
			check("armed", 1, run_o);
			expire(rows[i]);
		end
		sel = 0;
		iowdt_host_i.access(0, 8'h02);
		repeat (15) @(posedge clock_i);
		iowdt_host_i.access(0, 8'h01);
		expire(7'h01);
		iowdt_host_i.access(0, 8'h03);
		iowdt_host_i.access(1, 8'h00);
		check("rdata", 3, rdata);
		@(posedge clock_i) #1;
		check("rdata clear", 0, rdata);
		repeat (40) @(posedge clock_i);
		#1 check("disarmed", 0, {rst_o, irq_o, run_o});
		iowdt_host_i.access(0, 8'h05);
		@(posedge clock_i) #1 arst_n_i = 0;
		#1 check("reset", 0, {rst_o, irq_o, run_o});
		@(posedge clock_i) #1 arst_n_i = 1;
		repeat (80) @(posedge clock_i);
		#1 check("after reset", 0, {rst_o, irq_o, run_o});
		stop_test();
	end
	initial
	begin
		#100000;
		failures++;
		stop_test();
	end
endmodule // io_port_watchdog_timer_test
